// ### design/motor_wave_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef MOTOR_WAVE_DEFS_SVH
`define MOTOR_WAVE_DEFS_SVH
`define OFS_EMG_CTRL 16'h1fb0
`define OFS_OVL_CTRL 16'h1fb4
`define OFS_ANGLE_CTRL 16'h1fc0
`define OFS_PERIOD 16'h1fc4
`define OFS_ANGLE 16'h1fc8
`define OFS_CAPTURE 16'h1fcc
`define OFS_SINE_DATA 16'h1fd0
`define OFS_AMPLITUDE 16'h1fd4
`define OFS_PWM_PERIOD 16'h1fd8
`define OFS_CMP_U 16'h1fdc
`define OFS_CMP_V 16'h1fe0
`define OFS_CMP_W 16'h1fe4
`define OFS_CALC_STAT 16'h1fe8
`define OVL_RELEASE_BIT 7
`define OVL_PWM_EN_BIT 6
`define OVL_TMR_EN_BIT 5
`define OVL_ACTIVE_BIT 4
`define OVL_SEL_MSB 3
`define OVL_SEL_LSB 2
`define OVL_HALT_BIT 1
`define OVL_GUARD_BIT 0
`define EMG_COUNT_MSB 7
`define EMG_COUNT_LSB 4
`define EMG_ACTIVE_BIT 2
`define EMG_RELEASE_BIT 1
`define EMG_GUARD_BIT 0
`define ACTL_TIMER_EN_BIT 0
`define ACTL_CALC_EN_BIT 1
`define ACTL_XFER_EN_BIT 2
`define ACTL_THREE_PH_BIT 3
`define PER_CORR_MSB 15
`define PER_CORR_LSB 12
`define PER_VAL_MSB 11
`define PER_VAL_LSB 0
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define RST_OVL_CTRL 8'h00
`define RST_EMG_CTRL 8'h01
`define RST_PERIOD 16'h0010
`define PERIOD_FLOOR 12'h010
`define ANGLE_LAST 9'h17f
`define ANGLE_HALF 9'h0c0
`define ANGLE_120 9'h080
`define ANGLE_240 9'h100
`define SAMPLE_UNIT 4
`define CALC_TIME_NS 7000
`define CALC_CLK_NS 200
`define CALC_MAX_CYCLES (`CALC_TIME_NS / `CALC_CLK_NS)
`endif

// ### design/motor_wave_pkg.sv
// types shared by the motor waveform and protection block
package motor_wave_pkg;
    typedef enum logic [1:0] {
        calc_idle = 2'b00,
        calc_fetch = 2'b01,
        calc_mul = 2'b10,
        calc_store = 2'b11
    } calc_state_e;
    typedef enum logic [1:0] {
        block_none = 2'b00,
        block_all = 2'b01,
        block_pwm = 2'b10,
        block_group = 2'b11
    } block_sel_e;
endpackage

// ### design/motor_waveform_protection.sv
// overload/emergency protection, electrical angle timer and waveform arithmetic
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/10ps
`include "motor_wave_defs.svh"
module motor_waveform_protection #(
    parameter int DATA_W = 16,
    parameter int TABLE_DEPTH = 384
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // avalon-mm register slave
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // protection pins
    input wire logic overload_in,
    input wire logic emergency_stop_input_n,
    // events from neighbouring logic
    input wire logic pwm_sync,
    input wire logic timer_sync,
    input wire logic position_detect,
    // phase state from the pwm generator
    input wire logic [2:0] upper_on,
    input wire logic [2:0] lower_on,
    input wire logic [5:0] pwm_phase_mask,
    // to the pwm generator
    output logic [2:0] block_upper,
    output logic [2:0] block_lower,
    output logic pwm_counter_halt,
    output logic [DATA_W-1:0] duty_u,
    output logic [DATA_W-1:0] duty_v,
    output logic [DATA_W-1:0] duty_w,
    output logic duty_load,
    output logic angle_irq
);
    // bus handshake: one wait cycle, read data registered
    logic ack;
    logic req;
    logic wr_fire;
    logic [31:0] wmask;
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack;
    assign wr_fire = avs_write & ack;
    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= req & ~ack;
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [31:0] m);
        merge = (old & ~m) | (wd & m);
    endfunction

    function automatic logic wr_at(input logic [15:0] a, input logic [15:0] ofs);
        wr_at = (a == ofs);
    endfunction

    // pin synchronisers
    logic ovl_s1, ovl_s2, emg_s1, emg_s2;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ovl_s1 <= 1'b0;
            ovl_s2 <= 1'b0;
            emg_s1 <= 1'b1;
            emg_s2 <= 1'b1;
        end else begin
            ovl_s1 <= overload_in;
            ovl_s2 <= ovl_s1;
            emg_s1 <= emergency_stop_input_n;
            emg_s2 <= emg_s1;
        end
    end

    // protection control registers
    logic release_on_pwm_sync_en, release_on_timer_sync_en;
    logic [1:0] overload_phase_block_sel;
    logic overload_counter_halt, overload_guard_en;
    logic [3:0] overload_sample_count;
    logic emergency_guard_en;
    logic wr_ovl, wr_emg;
    assign wr_ovl = wr_fire & wr_at(avs_address, `OFS_OVL_CTRL) & avs_byteenable[0];
    assign wr_emg = wr_fire & wr_at(avs_address, `OFS_EMG_CTRL) & avs_byteenable[0];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            release_on_pwm_sync_en <= 1'(`RST_OVL_CTRL >> `OVL_PWM_EN_BIT);
            release_on_timer_sync_en <= 1'b0;
            overload_phase_block_sel <= 2'b00;
            overload_counter_halt <= 1'b0;
            overload_guard_en <= 1'b0;
            overload_sample_count <= 4'h0;
            emergency_guard_en <= 1'b1;
        end else begin
            if (wr_ovl) begin
                release_on_pwm_sync_en <= avs_writedata[`OVL_PWM_EN_BIT];
                release_on_timer_sync_en <= avs_writedata[`OVL_TMR_EN_BIT];
                overload_phase_block_sel <= avs_writedata[`OVL_SEL_MSB:`OVL_SEL_LSB];
                overload_counter_halt <= avs_writedata[`OVL_HALT_BIT];
                overload_guard_en <= avs_writedata[`OVL_GUARD_BIT];
            end
            if (wr_emg) begin
                overload_sample_count <= avs_writedata[`EMG_COUNT_MSB:`EMG_COUNT_LSB];
                emergency_guard_en <= avs_writedata[`EMG_GUARD_BIT];
            end
        end
    end

    // overload sampling every 4*n clocks, every 4 clocks when n is 0
    logic [5:0] sample_cnt;
    logic [5:0] sample_len;
    logic sample_tick;
    assign sample_len = (overload_sample_count == 4'h0) ? 6'h04 :
                        {overload_sample_count, 2'b00};
    assign sample_tick = (sample_cnt >= sample_len - 6'h01);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sample_cnt <= 6'h00;
        end else begin
            sample_cnt <= sample_tick ? 6'h00 : sample_cnt + 6'h01;
        end
    end

    // overload and emergency state; a new detection wins over a release
    logic overload_active_flag, emergency_active_flag;
    logic ovl_set, ovl_release;
    assign ovl_set = overload_guard_en & sample_tick & ovl_s2;
    assign ovl_release = (wr_ovl & avs_writedata[`OVL_RELEASE_BIT])
                       | (release_on_pwm_sync_en & pwm_sync)
                       | (release_on_timer_sync_en & timer_sync)
                       | ~overload_guard_en;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            overload_active_flag <= 1'b0;
        end else if (ovl_set) begin
            overload_active_flag <= 1'b1;
        end else if (ovl_release) begin
            overload_active_flag <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            emergency_active_flag <= 1'b0;
        end else if (emergency_guard_en & ~emg_s2) begin
            emergency_active_flag <= 1'b1;
        end else if (wr_emg & avs_writedata[`EMG_RELEASE_BIT] & emg_s2) begin
            emergency_active_flag <= 1'b0;
        end
    end

    // phase blocking
    logic [2:0] next_bu, next_bl;
    logic up_two, lo_two;
    assign up_two = (upper_on[0] & upper_on[1]) | (upper_on[0] & upper_on[2])
                  | (upper_on[1] & upper_on[2]);
    assign lo_two = (lower_on[0] & lower_on[1]) | (lower_on[0] & lower_on[2])
                  | (lower_on[1] & lower_on[2]);
    always_comb begin
        next_bu = 3'b000;
        next_bl = 3'b000;
        if (overload_active_flag) begin
            case (motor_wave_pkg::block_sel_e'(overload_phase_block_sel))
                motor_wave_pkg::block_none: begin
                    next_bu = 3'b000;
                end
                motor_wave_pkg::block_all: begin
                    next_bu = 3'b111;
                    next_bl = 3'b111;
                end
                motor_wave_pkg::block_pwm: begin
                    next_bu = pwm_phase_mask[2:0];
                    next_bl = pwm_phase_mask[5:3];
                end
                motor_wave_pkg::block_group: begin
                    if (up_two) begin
                        next_bl = 3'b111;
                    end else if (lo_two) begin
                        next_bu = 3'b111;
                    end
                end
                default: begin
                    next_bu = 3'b000;
                end
            endcase
        end
        if (emergency_active_flag) begin
            next_bu = 3'b111;
            next_bl = 3'b111;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            block_upper <= 3'b000;
            block_lower <= 3'b000;
            pwm_counter_halt <= 1'b0;
        end else begin
            block_upper <= next_bu;
            block_lower <= next_bl;
            pwm_counter_halt <= overload_counter_halt & overload_active_flag;
        end
    end

    // angle timer control registers
    logic timer_en, wave_calc_en, result_transfer_en, three_phase;
    logic [15:0] angle_period_setting;
    logic [DATA_W-1:0] amplitude, pwm_period;
    logic wr_actl, wr_angle, wr_sine;
    // byte-masked update of the period word, cut back to 16 bits below
    logic [31:0] period_merged;
    assign period_merged = merge({16'h0000, angle_period_setting}, avs_writedata, wmask);
    assign wr_actl = wr_fire & wr_at(avs_address, `OFS_ANGLE_CTRL);
    assign wr_angle = wr_fire & wr_at(avs_address, `OFS_ANGLE);
    assign wr_sine = wr_fire & wr_at(avs_address, `OFS_SINE_DATA);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            timer_en <= 1'b0;
            wave_calc_en <= 1'b0;
            result_transfer_en <= 1'b0;
            three_phase <= 1'b0;
            angle_period_setting <= `RST_PERIOD;
            amplitude <= '0;
            pwm_period <= '0;
        end else if (wr_fire) begin
            if (wr_actl & avs_byteenable[0]) begin
                timer_en <= avs_writedata[`ACTL_TIMER_EN_BIT];
                wave_calc_en <= avs_writedata[`ACTL_CALC_EN_BIT];
                result_transfer_en <= avs_writedata[`ACTL_XFER_EN_BIT];
                three_phase <= avs_writedata[`ACTL_THREE_PH_BIT];
            end
            if (wr_at(avs_address, `OFS_PERIOD)) begin
                angle_period_setting <= period_merged[15:0];
            end
            if (wr_at(avs_address, `OFS_AMPLITUDE)) begin
                amplitude <= DATA_W'(avs_writedata);
            end
            if (wr_at(avs_address, `OFS_PWM_PERIOD)) begin
                pwm_period <= DATA_W'(avs_writedata);
            end
        end
    end

    // angle timer with spread period correction
    logic [11:0] angle_period_value;
    logic [11:0] tmr;
    logic [4:0] corr_acc;
    logic stretch, tmr_done;
    logic [8:0] angle_counter, angle_capture;
    assign angle_period_value = (angle_period_setting[`PER_VAL_MSB:`PER_VAL_LSB] < `PERIOD_FLOOR)
        ? `PERIOD_FLOOR : angle_period_setting[`PER_VAL_MSB:`PER_VAL_LSB];
    // accumulator carry spreads the n long steps evenly over 16
    assign stretch = ({1'b0, corr_acc[3:0]} + {1'b0, angle_period_setting[15:12]}) >= 5'h10;
    assign tmr_done = timer_en & (tmr >= angle_period_value - 12'h001 + {11'h000, stretch});
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tmr <= 12'h000;
            corr_acc <= 5'h00;
        end else if (!timer_en) begin
            tmr <= 12'h000;
            corr_acc <= 5'h00;
        end else if (tmr_done) begin
            tmr <= 12'h000;
            corr_acc <= {1'b0, corr_acc[3:0] + angle_period_setting[15:12]};
        end else begin
            tmr <= tmr + 12'h001;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            angle_counter <= 9'h000;
            angle_irq <= 1'b0;
            angle_capture <= 9'h000;
        end else begin
            angle_irq <= tmr_done;
            if (wr_angle) begin
                angle_counter <= avs_writedata[8:0] > `ANGLE_LAST ? 9'h000
                               : avs_writedata[8:0];
            end else if (tmr_done) begin
                angle_counter <= (angle_counter >= `ANGLE_LAST) ? 9'h000
                               : angle_counter + 9'h001;
            end
            if (position_detect) begin
                angle_capture <= angle_counter;
            end
        end
    end

    // sine table, filled at the angle counter address
    logic [DATA_W-1:0] sine_ram [TABLE_DEPTH];
    logic [DATA_W-1:0] ram_q;
    logic [8:0] look_angle;
    always_ff @(posedge mclk) begin
        if (wr_sine) begin
            sine_ram[angle_counter] <= DATA_W'(avs_writedata);
        end
        ram_q <= sine_ram[look_angle];
    end

    // waveform sequencer: u, v, w, 3 clocks each (fetch, mul, store)
    motor_wave_pkg::calc_state_e calc_state;
    logic [1:0] phase_idx;
    logic [8:0] base_angle;
    logic [2*DATA_W-1:0] product;
    logic [DATA_W-1:0] res_u, res_v, res_w, next_res;
    logic calc_start, calc_done;
    logic [9:0] shifted;
    assign calc_start = wave_calc_en & (tmr_done | wr_angle);
    assign shifted = {1'b0, base_angle} + ((phase_idx == 2'd1) ? {1'b0, `ANGLE_120} :
                     (phase_idx == 2'd2) ? {1'b0, `ANGLE_240} : 10'h000);
    assign look_angle = (shifted > {1'b0, `ANGLE_LAST}) ? 9'(shifted - 10'd384) : shifted[8:0];

    always_comb begin
        next_res = product[2*DATA_W-1:DATA_W];
        if (three_phase) begin
            if (look_angle < `ANGLE_HALF) begin
                next_res = (pwm_period >> 1) + (product[2*DATA_W-1:DATA_W] >> 1);
            end else if ((pwm_period >> 1) > (product[2*DATA_W-1:DATA_W] >> 1)) begin
                next_res = (pwm_period >> 1) - (product[2*DATA_W-1:DATA_W] >> 1);
            end else begin
                next_res = '0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            calc_state <= motor_wave_pkg::calc_idle;
            phase_idx <= 2'd0;
            base_angle <= 9'h000;
            product <= '0;
            res_u <= '0;
            res_v <= '0;
            res_w <= '0;
            calc_done <= 1'b0;
        end else if (calc_start) begin
            // a restart begins again at phase u; results already stored are kept, results_ready clears unless calc_done is high in the same cycle
            calc_state <= motor_wave_pkg::calc_fetch;
            phase_idx <= 2'd0;
            base_angle <= wr_angle ? avs_writedata[8:0] : angle_counter;
            calc_done <= 1'b0;
        end else begin
            calc_done <= 1'b0;
            case (calc_state)
                motor_wave_pkg::calc_idle: begin
                    phase_idx <= 2'd0;
                end
                motor_wave_pkg::calc_fetch: begin
                    calc_state <= motor_wave_pkg::calc_mul;
                end
                motor_wave_pkg::calc_mul: begin
                    product <= ram_q * amplitude;
                    calc_state <= motor_wave_pkg::calc_store;
                end
                motor_wave_pkg::calc_store: begin
                    if (phase_idx == 2'd0) begin
                        res_u <= next_res;
                    end
                    if (phase_idx == 2'd1) begin
                        res_v <= next_res;
                    end
                    if (phase_idx == 2'd2) begin
                        res_w <= next_res;
                        calc_done <= 1'b1;
                        calc_state <= motor_wave_pkg::calc_idle;
                    end else begin
                        phase_idx <= phase_idx + 2'd1;
                        calc_state <= motor_wave_pkg::calc_fetch;
                    end
                end
                default: begin
                    calc_state <= motor_wave_pkg::calc_idle;
                end
            endcase
        end
    end

    // compare registers and status
    logic results_ready;
    logic wr_cmp_ok;
    assign wr_cmp_ok = wr_fire & ~result_transfer_en;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            duty_u <= '0;
            duty_v <= '0;
            duty_w <= '0;
            duty_load <= 1'b0;
            results_ready <= 1'b0;
        end else begin
            duty_load <= 1'b0;
            if (calc_done & wave_calc_en & result_transfer_en) begin
                duty_u <= res_u;
                duty_v <= res_v;
                duty_w <= res_w;
                duty_load <= 1'b1;
            end else if (wr_cmp_ok) begin
                if (wr_at(avs_address, `OFS_CMP_U)) begin
                    duty_u <= DATA_W'(avs_writedata);
                end
                if (wr_at(avs_address, `OFS_CMP_V)) begin
                    duty_v <= DATA_W'(avs_writedata);
                end
                if (wr_at(avs_address, `OFS_CMP_W)) begin
                    duty_w <= DATA_W'(avs_writedata);
                end
                duty_load <= wr_at(avs_address, `OFS_CMP_U) | wr_at(avs_address, `OFS_CMP_V)
                           | wr_at(avs_address, `OFS_CMP_W);
            end
            if (calc_done) begin
                results_ready <= 1'b1;
            end else if (calc_start) begin
                results_ready <= 1'b0;
            end
        end
    end

    // read mux; write-only bits read as zero
    logic [31:0] next_rd;
    logic [DATA_W-1:0] cmp_u_rd, cmp_v_rd, cmp_w_rd;
    assign cmp_u_rd = result_transfer_en ? duty_u : res_u;
    assign cmp_v_rd = result_transfer_en ? duty_v : res_v;
    assign cmp_w_rd = result_transfer_en ? duty_w : res_w;
    always_comb begin
        next_rd = 32'h0000_0000;
        case (avs_address)
            `OFS_OVL_CTRL: next_rd = {24'h000000, 1'b0, release_on_pwm_sync_en,
                release_on_timer_sync_en, overload_active_flag, overload_phase_block_sel,
                overload_counter_halt, overload_guard_en};
            `OFS_EMG_CTRL: next_rd = {24'h000000, overload_sample_count, 1'b0,
                emergency_active_flag, 1'b0, emergency_guard_en};
            `OFS_ANGLE_CTRL: next_rd = {28'h0000000, three_phase, result_transfer_en,
                wave_calc_en, timer_en};
            `OFS_PERIOD: next_rd = {16'h0000, angle_period_setting};
            `OFS_ANGLE: next_rd = {23'h000000, angle_counter};
            `OFS_CAPTURE: next_rd = {23'h000000, angle_capture};
            `OFS_AMPLITUDE: next_rd = 32'(amplitude);
            `OFS_PWM_PERIOD: next_rd = 32'(pwm_period);
            `OFS_CMP_U: next_rd = 32'(cmp_u_rd);
            `OFS_CMP_V: next_rd = 32'(cmp_v_rd);
            `OFS_CMP_W: next_rd = 32'(cmp_w_rd);
            `OFS_CALC_STAT: next_rd = {30'h00000000, results_ready,
                calc_state != motor_wave_pkg::calc_idle};
            default: next_rd = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read & ~ack) begin
            avs_readdata <= next_rd;
        end
    end
endmodule

// ### verif/mwp_chk_asserts.sv
// port checker for the motor waveform block
`timescale 1ns/10ps
module mwp_chk #(parameter int DATA_W = 16) (
    // bus, events, duty
    input wire logic mclk, rst_n, avs_read, avs_write, avs_waitrequest, angle_irq, duty_load,
    input wire logic [DATA_W-1:0] duty_u, duty_v, duty_w
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    a_wait_first: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest)
        else $error("no wait");
    a_wait_once: assert property (avs_waitrequest |=> !avs_waitrequest)
        else $error("long wait");
    a_irq_pulse: assert property (angle_irq |=> !angle_irq)
        else $error("irq wide");
    a_irq_floor: assert property (angle_irq |=> !angle_irq [*8])
        else $error("step short");
    a_load_pulse: assert property (duty_load |=> !duty_load)
        else $error("load wide");
    a_load_gap: assert property (duty_load && !$past(avs_write) |=>
        (!duty_load || $past(avs_write)) [*8]) else $error("calc short");
    a_u_cause: assert property ($changed(duty_u) |-> duty_load)
        else $error("u moved");
    a_vw_cause: assert property ($changed({duty_v, duty_w}) |-> duty_load)
        else $error("vw moved");
    c_irq: cover property (angle_irq);
    c_load: cover property (duty_load);
    c_wait: cover property (avs_waitrequest);
endmodule
bind motor_waveform_protection mwp_chk #(.DATA_W(DATA_W)) chk_i (.*);

// ### verif/pwm_gen_model.sv
// pwm generator stand-in: phase states and period sync
`timescale 1ns/10ps
module pwm_gen_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [5:0] on_pat,
    output logic [2:0] upper_on,
    output logic [2:0] lower_on,
    output logic pwm_sync
);
    logic [3:0] cnt;
    assign upper_on = on_pat[2:0];
    assign lower_on = on_pat[5:3];
    assign pwm_sync = &cnt;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) cnt <= 4'h0;
        else cnt <= cnt + 4'h1;
    end
endmodule

// ### verif/motor_waveform_protection_test.sv
// self-checking bench for the motor waveform block
`timescale 1ns/10ps
`include "motor_wave_defs.svh"
module motor_waveform_protection_test;
    logic mclk = 0, rst_n = 0, avs_read = 0, avs_write = 0, overload_in = 0, timer_sync = 0;
    logic emergency_stop_input_n = 1, position_detect = 0, pwm_sync, duty_load, angle_irq;
    logic avs_waitrequest, pwm_counter_halt;
    logic [2:0] upper_on, lower_on, block_upper, block_lower;
    logic [3:0] avs_byteenable = 4'hf;
    logic [5:0] on_pat = 0, pwm_phase_mask = 0;
    logic [15:0] avs_address = 0, duty_u, duty_v, duty_w;
    logic [31:0] avs_writedata = 0, avs_readdata, q;
    logic [15:0] ra[4] = '{`OFS_OVL_CTRL, `OFS_EMG_CTRL, `OFS_ANGLE, 16'h1ffc};
    logic [31:0] rw[4] = '{32'hff, 32'hf3, 32'h17f, 32'h55};
    logic [31:0] re[4] = '{32'h6f, 32'hf1, 32'h17f, 32'h0};
    int error_cnt = 0, num_checks = 0, n;
    motor_waveform_protection DUT (.*);
    pwm_gen_model far_end (.*);
    initial forever #5 mclk = ~mclk;
    task automatic chk(input string s, input logic [47:0] got, input logic [47:0] exp);
        num_checks++;
        if (got !== exp) error_cnt++;
        if (got !== exp) $display("CHECK FAILED %s exp %h got %h", s, exp, got);
    endtask
    task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
        {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        {avs_write, avs_read} <= 2'b00;
        @(posedge mclk);
    endtask
    task automatic summarize;
        if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        summarize;
    end
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1;
        @(posedge mclk);
        acc(0, `OFS_EMG_CTRL, 0);
        chk("rst", q, 48'h01);
        for (int i = 0; i < 4; i++) begin
            acc(1, ra[i], rw[i]);
            acc(0, ra[i], 0);
            chk("reg", q, re[i]);
        end
        acc(1, `OFS_EMG_CTRL, 1);
        on_pat <= 6'h03;
        acc(1, `OFS_OVL_CTRL, 32'h0f);
        overload_in <= 1;
        repeat (12) @(posedge mclk);
        chk("grp", {pwm_counter_halt, block_upper, block_lower}, 48'h47);
        overload_in <= 0;
        acc(1, `OFS_OVL_CTRL, 32'h4f);
        repeat (30) @(posedge mclk);
        acc(0, `OFS_OVL_CTRL, 0);
        chk("rel", q, 48'h4f);
        for (int i = 0; i < 3; i++) begin
            acc(1, `OFS_ANGLE, i * 128);
            acc(1, `OFS_SINE_DATA, (i + 1) * 32'h1000);
        end
        acc(1, `OFS_AMPLITUDE, 32'h8000);
        acc(1, `OFS_ANGLE_CTRL, 6);
        acc(1, `OFS_ANGLE, 0);
        for (n = 0; duty_load !== 1'b1; n++) @(negedge mclk);
        chk("lat", n <= 35, 1);
        chk("uvw", {duty_u, duty_v, duty_w}, 48'h080010001800);
        @(posedge mclk);
        acc(1, `OFS_CMP_U, 32'h1234);
        acc(0, `OFS_CMP_U, 0);
        chk("blk", q, 48'h0800);
        acc(1, `OFS_AMPLITUDE, 32'h4000);
        acc(1, `OFS_ANGLE_CTRL, 2);
        acc(1, `OFS_ANGLE, 0);
        repeat (40) @(posedge mclk);
        acc(0, `OFS_CMP_V, 0);
        chk("res", q, 48'h0800);
        acc(1, `OFS_PWM_PERIOD, 32'h1000);
        acc(1, `OFS_ANGLE_CTRL, 32'ha);
        acc(1, `OFS_ANGLE, 0);
        repeat (40) @(posedge mclk);
        acc(0, `OFS_CMP_W, 0);
        chk("3ph", q, 48'h0200);
        acc(1, `OFS_PERIOD, 5);
        acc(1, `OFS_ANGLE, 32'h17e);
        acc(1, `OFS_ANGLE_CTRL, 1);
        do @(negedge mclk); while (angle_irq !== 1'b1);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (angle_irq !== 1'b1);
        chk("step", n, 16);
        @(posedge mclk);
        acc(0, `OFS_ANGLE, 0);
        chk("wrap", q, 0);
        acc(1, `OFS_ANGLE_CTRL, 0);
        acc(1, `OFS_ANGLE, 32'haa);
        position_detect <= 1;
        @(posedge mclk);
        position_detect <= 0;
        acc(0, `OFS_CAPTURE, 0);
        chk("cap", q, 48'haa);
        summarize;
    end
endmodule
